// [hw/csof_framer.sv]
// Purpose: Camera serial output framer with APB registers and pixel FIFO
// Assumes: link_clk is asynchronous to pclk and sampled as a pin
// Notes:   At most one word leaves per link_clk rising edge
`timescale 1ns/1ps
`include "csof_params.svh"

// Pixel FIFO with registered full and empty flags
module csof_fifo #(
    parameter int W = 10,
    parameter int D = 4
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Fill side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // Drain side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                full;
        logic                empty;
        logic                rdy;
    } csof_fifo_st_t;
    csof_fifo_st_t s_reg, s_next;
    logic push, pop;

    // Depth must be a power of two of at least two
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    // Next state of pointers, count and flags
    always_comb begin
        s_next = s_reg;
        push   = in_valid & ~s_reg.full;
        pop    = out_ready & ~s_reg.empty;
        if (push) begin
            s_next.mem[s_reg.wp] = in_data;
            s_next.wp = s_reg.wp + AW'(1);
        end
        if (pop) begin
            s_next.rp = s_reg.rp + AW'(1);
        end
        s_next.cnt   = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        s_next.full  = (s_next.cnt == (AW+1)'(D));
        s_next.empty = (s_next.cnt == '0);
        s_next.rdy   = ~s_next.full;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg       <= '0;
            s_reg.empty <= 1'b1;
            s_reg.rdy   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign in_ready  = s_reg.rdy; // Straight from a flop, no gate
    assign out_valid = ~s_reg.empty;
    assign out_data  = s_reg.mem[s_reg.rp];
endmodule

// What this block does
// - Format register picks CCP2 data/clock, data/strobe or CSI-2 (reset).
// - Each CSI-2 lane runs up to 840 Mbps, 1.68 Gbps for two.
// - Single-lane CSI-2 stays at or below 1.0 Gbps.
// - The CCP2 lane carries up to 640 Mbps.
// - Data lanes are transmit-only with high-speed and low-power states.
// - Clock lane is transmit-only with high-speed and low-power states.
// - Each data lane register: bit 0 inverts, bit 1 swaps P and N.
// - Clock lane register: bit 0 inverts, bit 1 swaps P and N.
// - Every frame opens with three embedded data lines.
// - Eight dummy columns precede the visible pixels of each line.
// - Embedded lines report the frame's integration time and gain.
// - Visible pixel count follows the requested frame size.
// - No dark, black or maker-specific pixels are sent.
// - CCP2 line blanking drives all data bits to one.
// - CCP2 frame blanking drives all data bits to one.
// - CSI-2 line blanking is spent in low-power state.
// - CSI-2 frame blanking is spent in low-power state.
module csof_framer
    import csof_pkg::*;
#(
    parameter int PIX_W      = 10,
    parameter int FIFO_DEPTH = 4,
    parameter int LANE_MBPS  = 840,
    parameter int CCP_MBPS   = 640
) (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // APB slave
    input  wire csof_pkg::csof_apb_req_t apb_req,
    output csof_pkg::csof_apb_rsp_t      apb_rsp,
    // Pixel stream in
    input  wire logic [PIX_W-1:0] pix_data,
    input  wire logic             pix_valid,
    output logic                  pix_ready,
    // Serial link
    input  wire logic             link_clk,
    output csof_pkg::csof_link_t  link
);
    import csof_pkg::*;

    // Parameter checks, including the lane rate ceilings
    if (PIX_W < 8 || PIX_W > 16) begin : g_bad_pix
        $error("pixel width must be 8 to 16");
    end
    if (LANE_MBPS > `CSOF_CSI_LANE_MBPS) begin : g_bad_lane
        $error("lane rate above the two-lane ceiling");
    end
    if (LANE_MBPS > `CSOF_CSI_ONE_MBPS) begin : g_bad_one
        $error("lane rate above the single-lane ceiling");
    end
    if (CCP_MBPS > `CSOF_CCP_MBPS) begin : g_bad_ccp
        $error("ccp rate above its ceiling");
    end

    typedef struct packed {
        logic [7:0]  fmt;
        logic [1:0]  dl1;
        logic [1:0]  dl2;
        logic [1:0]  ckl;
        logic [1:0]  ctrl;
        logic [15:0] xsize;
        logic [15:0] ysize;
        logic [15:0] hblank;
        logic [15:0] vblank;
        logic [15:0] expo;
        logic [7:0]  gain;
        csof_state_t st;
        logic [15:0] cnt;
        logic [15:0] line;
        logic [15:0] cur_x;
        logic [15:0] cur_y;
        logic [15:0] frames;
        logic        sel;
        logic        tog;
        logic [15:0] raw0;
        logic [15:0] raw1;
        logic        lk1;
        logic        lk2;
        logic        lk3;
        logic        lk_lvl;
        csof_apb_rsp_t rsp;
        csof_link_t  lnk;
    } csof_st_t;
    csof_st_t s_reg, s_next;

    logic [PIX_W-1:0] f_data;
    logic             f_valid;
    logic             f_pop;
    logic             tick;
    logic             acc;
    logic             bad;
    logic             ccp;
    logic             two;
    logic             hs;
    logic             emit;
    logic [15:0]      word;
    logic [31:0]      rd;

    // Pixel FIFO between source and framer
    csof_fifo #(.W(PIX_W), .D(FIFO_DEPTH)) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   (pix_data),
        .in_valid  (pix_valid),
        .in_ready  (pix_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_pop)
    );

    // Byte address match for a register index
    function automatic logic hit(logic [17:0] a, logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // Lane encode: low-power idles at all ones, else invert and swap
    function automatic csof_lane_t enc(logic [15:0] w, logic [1:0] c,
                                       logic h);
        csof_lane_t l;
        logic [15:0] v;
        v    = c[`CSOF_LANE_INV] ? ~w : w;
        l.hs = h;
        l.p  = h ? (c[`CSOF_LANE_SWAP] ? ~v : v) : `CSOF_ONES_WORD;
        l.n  = h ? (c[`CSOF_LANE_SWAP] ? v : ~v) : `CSOF_ONES_WORD;
        return l;
    endfunction

    // Register read mux
    always_comb begin
        bad = 1'b0;
        rd  = 32'h0000_0000;
        unique case (1'b1)
            hit(apb_req.paddr, `CSOF_IDX_FMT):    rd = 32'(s_reg.fmt);
            hit(apb_req.paddr, `CSOF_IDX_DL1):    rd = 32'(s_reg.dl1);
            hit(apb_req.paddr, `CSOF_IDX_DL2):    rd = 32'(s_reg.dl2);
            hit(apb_req.paddr, `CSOF_IDX_CKL):    rd = 32'(s_reg.ckl);
            hit(apb_req.paddr, `CSOF_IDX_CTRL):   rd = 32'(s_reg.ctrl);
            hit(apb_req.paddr, `CSOF_IDX_XSIZE):  rd = 32'(s_reg.xsize);
            hit(apb_req.paddr, `CSOF_IDX_YSIZE):  rd = 32'(s_reg.ysize);
            hit(apb_req.paddr, `CSOF_IDX_HBLANK): rd = 32'(s_reg.hblank);
            hit(apb_req.paddr, `CSOF_IDX_VBLANK): rd = 32'(s_reg.vblank);
            hit(apb_req.paddr, `CSOF_IDX_EXPO):   rd = 32'(s_reg.expo);
            hit(apb_req.paddr, `CSOF_IDX_GAIN):   rd = 32'(s_reg.gain);
            hit(apb_req.paddr, `CSOF_IDX_STATUS):
                rd = {s_reg.frames, 13'h0000, 3'(s_reg.st)};
            default: bad = 1'b1;
        endcase
    end

    // Next state: bus, sampler, framer and lane encoders
    always_comb begin
        s_next = s_reg;
        ccp    = (s_reg.fmt != `CSOF_FMT_CSI);
        two    = s_reg.ctrl[`CSOF_CTRL_TWO] & ~ccp;
        acc    = apb_req.psel & apb_req.penable;
        f_pop  = 1'b0;
        emit   = 1'b0;
        hs     = 1'b0;
        word   = `CSOF_ONES_WORD;

        // Access answered on its second cycle
        s_next.rsp.pready = acc & ~s_reg.rsp.pready;
        if (acc & ~s_reg.rsp.pready) begin
            s_next.rsp.prdata  = bad ? 32'h0000_0000 : rd;
            s_next.rsp.pslverr = bad;
        end else if (!acc) begin
            s_next.rsp.pslverr = 1'b0;
        end
        if (acc & s_reg.rsp.pready & apb_req.pwrite & ~s_reg.rsp.pslverr)
        begin
            // Format only moves in standby, codes above CSI-2 refused
            if (hit(apb_req.paddr, `CSOF_IDX_FMT) && s_reg.st == ST_IDLE
                && apb_req.pwdata[7:0] <= `CSOF_FMT_CSI)
                s_next.fmt = apb_req.pwdata[7:0];
            if (hit(apb_req.paddr, `CSOF_IDX_DL1))
                s_next.dl1 = apb_req.pwdata[1:0];
            if (hit(apb_req.paddr, `CSOF_IDX_DL2))
                s_next.dl2 = apb_req.pwdata[1:0];
            if (hit(apb_req.paddr, `CSOF_IDX_CKL))
                s_next.ckl = apb_req.pwdata[1:0];
            if (hit(apb_req.paddr, `CSOF_IDX_CTRL))
                s_next.ctrl = apb_req.pwdata[1:0];
            if (hit(apb_req.paddr, `CSOF_IDX_XSIZE))
                s_next.xsize = apb_req.pwdata[15:0];
            if (hit(apb_req.paddr, `CSOF_IDX_YSIZE))
                s_next.ysize = apb_req.pwdata[15:0];
            if (hit(apb_req.paddr, `CSOF_IDX_HBLANK))
                s_next.hblank = apb_req.pwdata[15:0];
            if (hit(apb_req.paddr, `CSOF_IDX_VBLANK))
                s_next.vblank = apb_req.pwdata[15:0];
            if (hit(apb_req.paddr, `CSOF_IDX_EXPO))
                s_next.expo = apb_req.pwdata[15:0];
            if (hit(apb_req.paddr, `CSOF_IDX_GAIN))
                s_next.gain = apb_req.pwdata[7:0];
        end

        // Link clock sampler; a level counts once stages two and three agree
        s_next.lk1 = link_clk;
        s_next.lk2 = s_reg.lk1;
        s_next.lk3 = s_reg.lk2;
        if (s_reg.lk2 == s_reg.lk3)
            s_next.lk_lvl = s_reg.lk2;
        tick = (s_reg.lk2 == s_reg.lk3) & s_reg.lk2 & ~s_reg.lk_lvl;

        // Framer: at most one word per link tick
        if (tick) begin
            unique case (s_reg.st)
                ST_IDLE: begin
                    s_next.cnt = '0;
                    if (s_reg.ctrl[`CSOF_CTRL_STREAM])
                        s_next.st = ST_FBLANK;
                end
                ST_FBLANK: begin
                    hs = ccp;
                    emit = ccp;
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (s_reg.cnt + 16'h0001 >= s_reg.vblank) begin
                        s_next.cnt = '0;
                        s_next.line = '0;
                        // Frame size retimed to the frame boundary
                        s_next.cur_x = s_reg.xsize;
                        s_next.cur_y = s_reg.ysize;
                        s_next.st = s_reg.ctrl[`CSOF_CTRL_STREAM] ?
                                    ST_LBLANK : ST_IDLE;
                    end
                end
                ST_LBLANK: begin
                    hs = ccp;
                    emit = ccp;
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (s_reg.cnt + 16'h0001 >= s_reg.hblank) begin
                        s_next.cnt = '0;
                        s_next.st = (s_reg.line < `CSOF_EMB_LINES) ?
                                    ST_EMB : ST_DUMMY;
                    end
                end
                ST_EMB: begin
                    hs = 1'b1;
                    emit = 1'b1;
                    // Words 0..2 of line 0 carry this frame's exposure, gain and format code
                    if (s_reg.cnt == 16'h0000 && s_reg.line == 16'h0000)
                        word = s_reg.expo;
                    else if (s_reg.cnt == 16'h0001 &&
                             s_reg.line == 16'h0000)
                        word = 16'(s_reg.gain);
                    else if (s_reg.cnt == 16'h0002 &&
                             s_reg.line == 16'h0000)
                        word = s_reg.fmt[7:0] | 16'h0000;
                    else
                        word = `CSOF_FILL_WORD;
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (s_reg.cnt == s_reg.cur_x - 16'h0001) begin
                        s_next.cnt = '0;
                        s_next.line = s_reg.line + 16'h0001;
                        s_next.st = ST_LBLANK;
                    end
                end
                ST_DUMMY: begin
                    hs = 1'b1;
                    emit = 1'b1;
                    word = `CSOF_FILL_WORD;
                    s_next.cnt = s_reg.cnt + 16'h0001;
                    if (s_reg.cnt == `CSOF_DUMMY_COLS - 16'h0001) begin
                        s_next.cnt = '0;
                        s_next.st = ST_VIS;
                    end
                end
                ST_VIS: begin
                    // Visible only; no dark or black columns exist
                    hs = 1'b1;
                    if (f_valid) begin
                        emit = 1'b1;
                        f_pop = 1'b1;
                        word = 16'(f_data);
                        s_next.cnt = s_reg.cnt + 16'h0001;
                        if (s_reg.cnt == s_reg.cur_x - 16'h0001) begin
                            s_next.cnt = '0;
                            s_next.line = s_reg.line + 16'h0001;
                            if (s_reg.line == `CSOF_EMB_LINES +
                                s_reg.cur_y - 16'h0001) begin
                                s_next.frames = s_reg.frames + 16'h0001;
                                s_next.st = ST_FBLANK;
                            end else begin
                                s_next.st = ST_LBLANK;
                            end
                        end
                    end
                end
            endcase

            // Steer the word; two lanes alternate in CSI-2
            if (emit) begin
                if (two && s_reg.sel)
                    s_next.raw1 = word;
                else
                    s_next.raw0 = word;
                s_next.sel = two & ~s_reg.sel;
                s_next.tog = ~s_reg.tog;
            end
            if (s_reg.st != ST_IDLE || s_reg.ctrl[`CSOF_CTRL_STREAM]) begin
                s_next.lnk.d0 = enc(s_next.raw0, s_reg.dl1, hs);
                s_next.lnk.d1 = enc(s_next.raw1, s_reg.dl2,
                                    hs & two);
                s_next.lnk.clk_hs = hs;
            end
        end

        // Clock lane: data/strobe folds data parity in, then invert and swap
        begin
            logic c;
            c = s_next.tog ^ ((s_reg.fmt == `CSOF_FMT_CCP_DS) &
                              ^s_next.raw0);
            c = c ^ s_reg.ckl[`CSOF_LANE_INV];
            s_next.lnk.clk_p = ~s_next.lnk.clk_hs | (s_reg.ckl[`CSOF_LANE_SWAP]
                               ? ~c : c);
            s_next.lnk.clk_n = ~s_next.lnk.clk_hs | (s_reg.ckl[`CSOF_LANE_SWAP]
                               ? c : ~c);
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg        <= '0;
            s_reg.fmt    <= `CSOF_FMT_RST;
            s_reg.dl1    <= `CSOF_LANE_RST;
            s_reg.dl2    <= `CSOF_LANE_RST;
            s_reg.ckl    <= `CSOF_LANE_RST;
            s_reg.ctrl   <= `CSOF_CTRL_RST;
            s_reg.xsize  <= `CSOF_XSIZE_RST;
            s_reg.ysize  <= `CSOF_YSIZE_RST;
            s_reg.hblank <= `CSOF_HBLANK_RST;
            s_reg.vblank <= `CSOF_VBLANK_RST;
            s_reg.expo   <= `CSOF_EXPO_RST;
            s_reg.gain   <= `CSOF_GAIN_RST;
            s_reg.st     <= ST_IDLE;
            s_reg.lnk    <= '1;
            s_reg.lnk.d0.hs <= 1'b0;
            s_reg.lnk.d1.hs <= 1'b0;
            s_reg.lnk.clk_hs <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign apb_rsp = s_reg.rsp;
    assign link    = s_reg.lnk;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_fmt_legal;
        s_reg.fmt <= `CSOF_FMT_CSI;
    endproperty
    a_fmt_legal: assert property (p_fmt_legal)
        else $error("format register holds an illegal code");

    property p_fmt_frozen;
        s_reg.st != ST_IDLE |=> $stable(s_reg.fmt);
    endproperty
    a_fmt_frozen: assert property (p_fmt_frozen)
        else $error("format changed while streaming");

    property p_ccp_lblank;
        tick && s_reg.st == ST_LBLANK && ccp
            |=> s_reg.raw0 == `CSOF_ONES_WORD && s_reg.lnk.d0.hs;
    endproperty
    a_ccp_lblank: assert property (p_ccp_lblank)
        else $error("ccp line blanking not all ones");

    property p_ccp_fblank;
        tick && s_reg.st == ST_FBLANK && ccp
            |=> s_reg.raw0 == `CSOF_ONES_WORD;
    endproperty
    a_ccp_fblank: assert property (p_ccp_fblank)
        else $error("ccp frame blanking not all ones");

    property p_csi_lblank;
        tick && s_reg.st == ST_LBLANK && !ccp |=> !s_reg.lnk.d0.hs
            && s_reg.lnk.d0.p == `CSOF_ONES_WORD;
    endproperty
    a_csi_lblank: assert property (p_csi_lblank)
        else $error("csi line blanking left low-power state");

    property p_csi_fblank;
        tick && s_reg.st == ST_FBLANK && !ccp |=> !s_reg.lnk.d0.hs
            && !s_reg.lnk.clk_hs;
    endproperty
    a_csi_fblank: assert property (p_csi_fblank)
        else $error("csi frame blanking left low-power state");

    property p_dummy_len;
        tick && s_reg.st == ST_DUMMY
            && s_reg.cnt == `CSOF_DUMMY_COLS - 16'h0001
            |=> s_reg.st == ST_VIS;
    endproperty
    a_dummy_len: assert property (p_dummy_len)
        else $error("dummy run is not eight columns");

    property p_emb_first;
        tick && s_reg.st == ST_EMB && s_reg.line == 16'h0000
            && s_reg.cnt == 16'h0000 && !two |=> s_reg.raw0 == s_reg.expo;
    endproperty
    a_emb_first: assert property (p_emb_first)
        else $error("first embedded word is not the exposure");

    property p_emb_count;
        tick && s_reg.st == ST_LBLANK && s_next.st != ST_LBLANK
            |-> (s_next.st == ST_EMB) == (s_reg.line < `CSOF_EMB_LINES);
    endproperty
    a_emb_count: assert property (p_emb_count)
        else $error("visible lines began after wrong embedded count");

    property p_lane_enc;
        s_reg.lnk.d0.hs && !s_reg.dl1[1] |-> s_reg.lnk.d0.p ==
            (s_reg.dl1[0] ? ~s_reg.raw0 : s_reg.raw0);
    endproperty
    a_lane_enc: assert property (p_lane_enc)
        else $error("data lane polarity wrong");

    property p_vis_end;
        tick && s_reg.st == ST_VIS && f_valid
            && s_reg.cnt == s_reg.cur_x - 16'h0001 |=> s_reg.st != ST_VIS;
    endproperty
    a_vis_end: assert property (p_vis_end)
        else $error("visible line length differs from frame size");

    c_frame: cover property (tick && s_reg.st == ST_VIS
        && s_next.st == ST_FBLANK);
    c_ccp: cover property (ccp && s_reg.lnk.d0.hs);
    c_two: cover property (two && s_reg.lnk.d1.hs);
endmodule

// [common/csof_params.svh]
// Purpose: Constants for the camera serial output framer
// Assumes: Register byte address is four times the register index
// Notes:   Included by the design file and by the bench
`ifndef CSOF_PARAMS_SVH
`define CSOF_PARAMS_SVH
// Register indices
`define CSOF_IDX_FMT      16'h0111
`define CSOF_IDX_DL1      16'h6006
`define CSOF_IDX_DL2      16'h6007
`define CSOF_IDX_CKL      16'h6008
`define CSOF_IDX_CTRL     16'h7000
`define CSOF_IDX_XSIZE    16'h7001
`define CSOF_IDX_YSIZE    16'h7002
`define CSOF_IDX_HBLANK   16'h7003
`define CSOF_IDX_VBLANK   16'h7004
`define CSOF_IDX_EXPO     16'h7005
`define CSOF_IDX_GAIN     16'h7006
`define CSOF_IDX_STATUS   16'h7007
// Output format codes
`define CSOF_FMT_CCP_DC   8'h00
`define CSOF_FMT_CCP_DS   8'h01
`define CSOF_FMT_CSI      8'h02
`define CSOF_FMT_RST      8'h02
// Field positions
`define CSOF_LANE_INV     0
`define CSOF_LANE_SWAP    1
`define CSOF_CTRL_STREAM  0
`define CSOF_CTRL_TWO     1
// Reset values
`define CSOF_LANE_RST     2'h0
`define CSOF_CTRL_RST     2'h2
`define CSOF_XSIZE_RST    16'h0020
`define CSOF_YSIZE_RST    16'h0018
`define CSOF_HBLANK_RST   16'h0010
`define CSOF_VBLANK_RST   16'h0020
`define CSOF_EXPO_RST     16'h0100
`define CSOF_GAIN_RST     8'h10
// Frame layout
`define CSOF_EMB_LINES    16'h0003
`define CSOF_DUMMY_COLS   16'h0008
`define CSOF_FILL_WORD    16'h0007
`define CSOF_ONES_WORD    16'hFFFF
// Line rates in Mbps
`define CSOF_CSI_LANE_MBPS 840
`define CSOF_CSI_ONE_MBPS  1000
`define CSOF_CCP_MBPS      640
`endif

// [common/csof_pkg.sv]
// Purpose: Types shared by the framer and its bench
// Assumes: Lane words are at most 16 bits wide
// Notes:   Constants live in csof_params.svh
package csof_pkg;
    // Framer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_FBLANK, ST_LBLANK, ST_EMB, ST_DUMMY, ST_VIS
    } csof_state_t;
    // APB request from the master
    typedef struct packed {
        logic [17:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } csof_apb_req_t;
    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } csof_apb_rsp_t;
    // One lane: p and n words, high-speed enable
    typedef struct packed {
        logic [15:0] p;
        logic [15:0] n;
        logic        hs;
    } csof_lane_t;
    // Whole output port
    typedef struct packed {
        csof_lane_t d0;
        csof_lane_t d1;
        logic       clk_p;
        logic       clk_n;
        logic       clk_hs;
    } csof_link_t;
endpackage

// [test/csof_rx_model.sv]
// Purpose: Receiver model: makes the link clock, logs lane 0 words
// Assumes: Link clock stands low while run is low
// Notes:   Words are taken mid-period, once settled
`timescale 1ns/1ps
module csof_rx_model (
    // Control
    input  wire logic                 run,
    // Link
    input  wire csof_pkg::csof_link_t link,
    output logic                      link_clk
);
    import csof_pkg::*;
    logic [15:0] words [$];
    // Link clock runs only while run is high
    initial begin
        link_clk = 1'b0;
        forever #32 link_clk = run & ~link_clk;
    end
    // Keep high-speed words only
    always @(negedge link_clk) begin
        if (link.d0.hs === 1'b1)
            words.push_back(link.d0.p);
    end
endmodule

// [test/test_camera_serial_output_framer.sv]
// Purpose: Self-checking bench for the serial output framer
// Assumes: CCP words on lane 0; pixels zero-extended to 16 bits
// Notes:   Registers via APB, one frame each for CCP data/clock and CSI-2 compared word by word
`timescale 1ns/1ps
`include "csof_params.svh"
module test_camera_serial_output_framer;
    import csof_pkg::*;
    logic pclk = 0, presetn = 0, pix_valid = 0, run = 0, link_clk, e;
    logic [9:0] pix_data = 0;
    logic pix_ready;
    csof_apb_req_t req = '0;
    csof_apb_rsp_t rsp;
    csof_link_t link;
    logic [31:0] q, r;
    logic [15:0] exp_q [$], pq [$];
    integer seed = 32'h3085_a94c, err_total = 0, check_count = 0;
    integer cyc = 0, i, j, m, f = 0;
    csof_framer u_csof_framer (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .apb_rsp(rsp), .pix_data(pix_data),
        .pix_valid(pix_valid), .pix_ready(pix_ready),
        .link_clk(link_clk), .link(link));
    csof_rx_model u_csof_rx_model (.run(run), .link(link),
        .link_clk(link_clk));
    initial forever #2 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        req <= '{paddr: {a, 2'b00}, psel: 1'b1, penable: 1'b0,
                 pwrite: w, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk); // One idle edge before the next request
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Timeout and random pixel feed
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (pix_valid && pix_ready === 1'b1) begin
            pq.push_back({6'h0, pix_data});
            pix_data <= 10'($random(seed));
        end
        if (cyc == 20000) begin
            err_total++;
            test_done;
        end
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `CSOF_IDX_FMT, 0);
        chk(q, 2);
        for (i = 0; i < 3; i++) begin
            apb(0, 16'(`CSOF_IDX_DL1 + i), 0);
            chk(q, 0);
            r = $random(seed) & 3;
            apb(1, 16'(`CSOF_IDX_DL1 + i), r);
            apb(0, 16'(`CSOF_IDX_DL1 + i), 0);
            chk(q, r);
            apb(1, 16'(`CSOF_IDX_DL1 + i), 0);
        end
        apb(0, 16'h0000, 0);
        chk({q[30:0], e}, 1);
        // CCP data/clock, 8 x 2 frame, short blanking; format set in standby
        apb(1, `CSOF_IDX_FMT, 0);
        for (i = 0; i < 4; i++)
            apb(1, 16'(`CSOF_IDX_XSIZE + i), i == 0 ? 8 : (i == 1 ? 2 : 4));
        // Pass 0 runs CCP data/clock, pass 1 single-lane CSI-2
        for (m = 0; m < 2; m++) begin
            apb(1, `CSOF_IDX_CTRL, 1);
            run <= 1'b1;
            pix_valid <= 1'b1;
            while (u_csof_rx_model.words.size() < 100) @(posedge pclk);
            // Format write refused while streaming
            apb(1, `CSOF_IDX_FMT, 2 - 2 * m);
            apb(0, `CSOF_IDX_FMT, 0);
            chk(q, 2 * m);
            // Model frame: embedded lines, then dummy plus pixels
            for (i = 0; i < 5; i++) begin
                if (i > 0 && m == 0)
                    repeat (4) exp_q.push_back(16'hffff);
                if (i > 2)
                    repeat (8) exp_q.push_back(`CSOF_FILL_WORD);
                for (j = 0; j < 8; j++)
                    if (i > 2)
                        exp_q.push_back(pq.pop_front());
                    else if (i == 0 && j < 3)
                        exp_q.push_back(j == 0 ? 16'h0100 :
                            (j == 1 ? 16'h0010 : 16'(2 * m)));
                    else
                        exp_q.push_back(`CSOF_FILL_WORD);
            end
            while (u_csof_rx_model.words[0] === 16'hffff)
                void'(u_csof_rx_model.words.pop_front());
            foreach (exp_q[k])
                chk(u_csof_rx_model.words[k], exp_q[k]);
            // Stop at frame end; drop pixels that later frames used
            apb(1, `CSOF_IDX_CTRL, 0);
            do
                apb(0, `CSOF_IDX_STATUS, 0);
            while (q[2:0] != 3'h0);
            repeat (16 * (q[31:16] - f - 1))
                void'(pq.pop_front());
            f = q[31:16];
            exp_q.delete();
            u_csof_rx_model.words.delete();
            apb(1, `CSOF_IDX_FMT, 2);
        end
        test_done;
    end
endmodule
